//--- hw/ccp_defines.svh
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// Register byte addresses on the AXI4-Lite slave.
`define CCP_OFF_CTRL     32'h0000_0000
`define CCP_OFF_CFG      32'h0000_0004
`define CCP_OFF_STATUS   32'h0000_0008

// Bit positions in the prescale control register.
`define CCP_B_MULT_ON    0
`define CCP_B_TCS        1
`define CCP_B_DIV_LO     2
`define CCP_B_DIV_HI     3
`define CCP_B_FIM        4

// Bit positions in the configuration register.
`define CCP_B_HALVE      0

// Bit positions in the status register.
`define CCP_B_ST_SRC     0
`define CCP_B_ST_DIV_LO  1
`define CCP_B_ST_DIV_HI  2
`define CCP_B_ST_IFAST   3
`define CCP_B_ST_PFAST   4
`define CCP_B_ST_OSCRUN  5

// AXI responses.
`define CCP_RESP_OKAY    2'h0
`define CCP_RESP_SLVERR  2'h2

// Reset values, and the divide field that fast mode uses.
`define CCP_CTRL_RST     5'h00
`define CCP_DIV_RST      2'h0
`define CCP_DIV_FAST     2'h0

// Internal oscillator model: half period in core clock cycles, minus one.
`define CCP_OSC_HALF     4'h5

`endif

//--- hw/ccp_pkg.sv
package ccp_pkg;

  typedef enum logic {
    CCP_SRC_OSC,
    CCP_SRC_EXT
  } ccp_src_e;

  typedef logic [1:0] ccp_div_t;

endpackage : ccp_pkg

//--- hw/ccp_mux_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ccp_mux_if;
  logic sel;
  logic clk_a;
  logic clk_b;
  logic clk_y;
  logic cur_sel;

  modport mux (input sel, input clk_a, input clk_b, output clk_y, output cur_sel);
  modport ctl (output sel, output clk_a, output clk_b, input clk_y, input cur_sel);
endinterface : ccp_mux_if

`default_nettype wire

//--- hw/ccp_gf_mux.sv
`timescale 1ns/1ps
`default_nettype none

// Glitch-free selector between two clock levels; sel 0 picks clk_a.
module ccp_gf_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ccp_mux_if.mux   m
);

  logic cur_sel_r;
  logic y_r;

  // The source only changes while both inputs and the output sit low, so
  // neither phase of the output can be cut short by a switch.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_sel_r <= 1'b0;
    end else if (m.sel != cur_sel_r && !m.clk_a && !m.clk_b && !y_r) begin
      cur_sel_r <= m.sel;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      y_r <= 1'b0;
    end else begin
      y_r <= cur_sel_r ? m.clk_b : m.clk_a;
    end
  end

  assign m.clk_y   = y_r;
  assign m.cur_sel = cur_sel_r;

  chk_switch_low_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cur_sel_r != $past(cur_sel_r)) |-> (!y_r && !$past(y_r)))
    else $error("Clock source switched outside a low phase.");

endmodule : ccp_gf_mux

`default_nettype wire

//--- hw/ccp_top.sv
// Summary of operation
// - Source select bit picks oscillator or external
// - Source select loaded during reset sequence
// - Source select defaults to internal oscillator
// - Oscillator stops only in halt or external
// - Normal instruction clock is reference divided by two
// - Halving bit divides multiplier reference by two
// - Multiplier x32 then divides by 1,2,4,8
// - Divide field selects 8/16/32/64 MHz timer clock
// - Multiplier enable powers multiplier, starts locking
// - Multiplier enable frozen while PWM timer runs
// - Timer select routes multiplier or instruction clock
// - Timer select guarded by enable and run
// - Divide change applies at PWM counter overflow
// - Divide field reads last written value
// - Fast mode uses the 00 divide output
// - Fast mode write forced clear when multiplier off
// - Instruction clock source switchable on the fly
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.svh"

module ccp_top (
  input  wire logic         CORE_CLK_I,
  input  wire logic         NRST_I,
  input  wire logic         CLK_SRC_STRAP_I,
  input  wire logic         EXT_CLK_I,
  input  wire logic         HALT_I,
  input  wire logic         PWM_RUN_I,
  input  wire logic         PWM_OVF_I,
  input  wire logic         MULT_X32_I,
  input  wire logic [31:0]  AWADDR_I,
  input  wire logic         AWVALID_I,
  output logic              AWREADY_O,
  input  wire logic [31:0]  WDATA_I,
  input  wire logic [3:0]   WSTRB_I,
  input  wire logic         WVALID_I,
  output logic              WREADY_O,
  output logic [1:0]        BRESP_O,
  output logic              BVALID_O,
  input  wire logic         BREADY_I,
  input  wire logic [31:0]  ARADDR_I,
  input  wire logic         ARVALID_I,
  output logic              ARREADY_O,
  output logic [31:0]       RDATA_O,
  output logic [1:0]        RRESP_O,
  output logic              RVALID_O,
  input  wire logic         RREADY_I,
  output ccp_pkg::ccp_src_e CLK_SRC_O,
  output logic              OSC_RUN_O,
  output logic              SELECTED_REF_CLK_O,
  output logic              MULT_REF_CLK_O,
  output logic              MULT_ON_O,
  output logic              INSTR_CLK_O,
  output logic              FAST_CORE_CLK_O,
  output logic              PWM_TIMER_CLK_O
);
  import ccp_pkg::*;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  // Source selection and internal oscillator.
  ccp_src_e src_sel_r;
  logic     loaded_r;
  logic [3:0] osc_cnt_r;
  logic     osc_r;
  logic     osc_run;
  logic     ref_lvl;
  logic     ref_prev_r;
  logic     ref_rise;

  // The strap is captured once, on the first edge after reset release,
  // which stands in for the end of the system reset sequence.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      src_sel_r <= CCP_SRC_OSC;
      loaded_r  <= 1'b0;
    end else if (!loaded_r) begin
      src_sel_r <= CLK_SRC_STRAP_I ? CCP_SRC_EXT : CCP_SRC_OSC;
      loaded_r  <= 1'b1;
    end
  end

  assign osc_run = !HALT_I && (src_sel_r == CCP_SRC_OSC);

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      osc_cnt_r <= 4'h0;
      osc_r     <= 1'b0;
    end else if (osc_run) begin
      if (osc_cnt_r == `CCP_OSC_HALF) begin
        osc_cnt_r <= 4'h0;
        osc_r     <= !osc_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 4'h1;
      end
    end
  end

  assign ref_lvl  = (src_sel_r == CCP_SRC_EXT) ? EXT_CLK_I : osc_r;
  assign ref_rise = ref_lvl && !ref_prev_r;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_lvl;
    end
  end

  // Register state.
  ccp_mux_if icm ();
  ccp_mux_if pcm ();
  logic     mult_on_r;
  logic     tcs_r;
  logic     fim_r;
  ccp_div_t div_sw_r;
  ccp_div_t div_eff_r;
  logic     halve_r;

  // AXI4-Lite slave.
  logic        aw_have_r;
  logic        w_have_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_cfg;

  assign AWREADY_O = !aw_have_r && !bvalid_r;
  assign WREADY_O  = !w_have_r && !bvalid_r;
  assign ARREADY_O = !rvalid_r;
  assign wr_go     = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ctrl   = wr_go && (awaddr_r == `CCP_OFF_CTRL) && wstrb_r[0];
  assign wr_cfg    = wr_go && (awaddr_r == `CCP_OFF_CFG) && wstrb_r[0];

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= 32'h0;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= AWADDR_I;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      w_have_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (WVALID_I && WREADY_O) begin
      w_have_r <= 1'b1;
      wdata_r  <= WDATA_I;
      wstrb_r  <= WSTRB_I;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CCP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      if (awaddr_r == `CCP_OFF_CTRL || awaddr_r == `CCP_OFF_CFG
          || awaddr_r == `CCP_OFF_STATUS) begin
        bresp_r <= `CCP_RESP_OKAY;
      end else begin
        bresp_r <= `CCP_RESP_SLVERR;
      end
    end else if (BREADY_I) begin
      bvalid_r <= 1'b0;
    end
  end

  assign BVALID_O = bvalid_r;
  assign BRESP_O  = bresp_r;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `CCP_RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (ARVALID_I && ARREADY_O) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `CCP_RESP_OKAY;
      rdata_r  <= 32'h0;
      if (ARADDR_I == `CCP_OFF_CTRL) begin
        rdata_r[`CCP_B_MULT_ON]            <= mult_on_r;
        rdata_r[`CCP_B_TCS]                <= tcs_r;
        rdata_r[`CCP_B_DIV_HI:`CCP_B_DIV_LO] <= div_sw_r;
        rdata_r[`CCP_B_FIM]                <= fim_r;
      end else if (ARADDR_I == `CCP_OFF_CFG) begin
        rdata_r[`CCP_B_HALVE] <= halve_r;
      end else if (ARADDR_I == `CCP_OFF_STATUS) begin
        rdata_r[`CCP_B_ST_SRC]                     <= src_sel_r;
        rdata_r[`CCP_B_ST_DIV_HI:`CCP_B_ST_DIV_LO] <= div_eff_r;
        rdata_r[`CCP_B_ST_IFAST]                   <= icm.cur_sel;
        rdata_r[`CCP_B_ST_PFAST]                   <= pcm.cur_sel;
        rdata_r[`CCP_B_ST_OSCRUN]                  <= osc_run;
      end else begin
        rresp_r <= `CCP_RESP_SLVERR;
      end
    end else if (RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  assign RVALID_O = rvalid_r;
  assign RRESP_O  = rresp_r;
  assign RDATA_O  = rdata_r;

  // Prescale control bits. Guards look at the state before the write.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mult_on_r <= 1'b0;
    end else if (wr_ctrl && !PWM_RUN_I) begin
      mult_on_r <= wdata_r[`CCP_B_MULT_ON];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tcs_r <= 1'b0;
    end else if (wr_ctrl && !PWM_RUN_I) begin
      if (!wdata_r[`CCP_B_TCS] || mult_on_r) begin
        tcs_r <= wdata_r[`CCP_B_TCS];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fim_r <= 1'b0;
    end else if (wr_ctrl) begin
      fim_r <= wdata_r[`CCP_B_FIM] && mult_on_r;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_sw_r <= `CCP_DIV_RST;
    end else if (wr_ctrl) begin
      div_sw_r <= wdata_r[`CCP_B_DIV_HI:`CCP_B_DIV_LO];
    end
  end

  // A divide written during a PWM cycle waits for the counter overflow.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_eff_r <= `CCP_DIV_RST;
    end else if (!PWM_RUN_I || PWM_OVF_I) begin
      div_eff_r <= div_sw_r;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      halve_r <= 1'b0;
    end else if (wr_cfg) begin
      halve_r <= wdata_r[`CCP_B_HALVE];
    end
  end

  // Reference derived clocks.
  logic mref_r;
  logic instr_div_r;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mref_r <= 1'b0;
    end else if (halve_r) begin
      if (ref_rise) begin
        mref_r <= !mref_r;
      end
    end else begin
      mref_r <= ref_lvl;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      instr_div_r <= 1'b0;
    end else if (ref_rise) begin
      instr_div_r <= !instr_div_r;
    end
  end

  // Multiplier output divider. The x32 product arrives from the analog core.
  logic       x_prev_r;
  logic [2:0] mdiv_r;
  logic       x_rise;
  logic       fast_lvl;
  logic       pwm_lvl;

  assign x_rise = MULT_X32_I && !x_prev_r;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      x_prev_r <= 1'b0;
      mdiv_r   <= 3'h0;
    end else if (!mult_on_r) begin
      x_prev_r <= 1'b0;
      mdiv_r   <= 3'h0;
    end else begin
      x_prev_r <= MULT_X32_I;
      if (x_rise) begin
        mdiv_r <= mdiv_r + 3'h1;
      end
    end
  end

  // Field 00 is the slowest output (divide by 8), 11 passes the product.
  always_comb begin
    pwm_lvl = 1'b0;
    case (div_eff_r)
      2'h0:    pwm_lvl = mdiv_r[2];
      2'h1:    pwm_lvl = mdiv_r[1];
      2'h2:    pwm_lvl = mdiv_r[0];
      default: pwm_lvl = MULT_X32_I && mult_on_r;
    endcase
  end

  assign fast_lvl = (`CCP_DIV_FAST == 2'h0) ? mdiv_r[2] : mdiv_r[0];

  // Glitch-free selection of the instruction and PWM timer clocks.
  assign icm.sel   = fim_r;
  assign icm.clk_a = instr_div_r;
  assign icm.clk_b = fast_lvl;
  assign pcm.sel   = tcs_r;
  assign pcm.clk_a = icm.clk_y;
  assign pcm.clk_b = pwm_lvl;

  ccp_gf_mux u_instr_mux (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (NRST_I),
    .m       (icm)
  );

  ccp_gf_mux u_pwm_mux (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (NRST_I),
    .m       (pcm)
  );

  // Clock data outputs come from flip-flops.
  logic osc_run_r;
  logic ref_o_r;
  logic fast_o_r;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      osc_run_r <= 1'b0;
      ref_o_r   <= 1'b0;
      fast_o_r  <= 1'b0;
    end else begin
      osc_run_r <= osc_run;
      ref_o_r   <= ref_lvl;
      fast_o_r  <= fast_lvl;
    end
  end

  assign CLK_SRC_O          = src_sel_r;
  assign OSC_RUN_O          = osc_run_r;
  assign SELECTED_REF_CLK_O = ref_o_r;
  assign MULT_REF_CLK_O     = mref_r;
  assign MULT_ON_O          = mult_on_r;
  assign INSTR_CLK_O        = icm.clk_y;
  assign FAST_CORE_CLK_O    = fast_o_r;
  assign PWM_TIMER_CLK_O    = pcm.clk_y;

  chk_src_strap_load: assert property ($rose(loaded_r) |->
    src_sel_r == ($past(CLK_SRC_STRAP_I) ? CCP_SRC_EXT : CCP_SRC_OSC))
    else $error("Source select not loaded from strap.");
  chk_src_default: assert property (!loaded_r |-> src_sel_r == CCP_SRC_OSC)
    else $error("Source select not at oscillator default.");
  chk_osc_stopped: assert property ((HALT_I || src_sel_r == CCP_SRC_EXT) |=>
    $stable(osc_r) && !osc_run_r)
    else $error("Oscillator ran while stopped.");
  chk_instr_half: assert property (ref_rise |=> instr_div_r != $past(instr_div_r))
    else $error("Instruction divider missed a reference edge.");
  chk_halve_hold: assert property ((halve_r && !ref_rise) |=> $stable(mref_r))
    else $error("Halved reference moved without an edge.");
  chk_mult_count: assert property ((mult_on_r && x_rise) |=>
    mdiv_r == $past(mdiv_r) + 3'h1)
    else $error("Multiplier divider missed a product edge.");
  chk_enable_frozen: assert property ((wr_ctrl && PWM_RUN_I) |=> $stable(mult_on_r))
    else $error("Multiplier enable changed while timer ran.");
  chk_tcs_guard: assert property ((wr_ctrl && (PWM_RUN_I || !mult_on_r) && !tcs_r)
    |=> !tcs_r)
    else $error("Timer select set against its guard.");
  chk_div_deferred: assert property ((PWM_RUN_I && !PWM_OVF_I) |=> $stable(div_eff_r))
    else $error("Divide changed inside a PWM cycle.");
  chk_fim_forced: assert property ((wr_ctrl && !mult_on_r) |=> !fim_r)
    else $error("Fast mode set with multiplier off.");

  cov_mult_enable: cover property (wr_ctrl && wdata_r[`CCP_B_MULT_ON] ##1 mult_on_r);
  cov_fast_mode:   cover property (fim_r ##[1:64] icm.cur_sel);
  cov_div_at_ovf:  cover property (PWM_RUN_I && PWM_OVF_I && div_sw_r != div_eff_r);

endmodule : ccp_top

`default_nettype wire

//--- testbench/ccp_far.sv
`timescale 1ns/1ps
`default_nettype none

module ccp_far (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_req_i,
  input  wire logic mult_on_i,
  output logic      ext_clk_o,
  output logic      mult_x32_o,
  output logic      pwm_run_o,
  output logic      pwm_ovf_o
);
  logic [1:0] ext_cnt_r;
  logic [5:0] pwm_cnt_r;

  // The external source runs from power-up, even through reset, three cycles high and three low.
  initial begin
    ext_cnt_r = 2'h0;
    ext_clk_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (ext_cnt_r == 2'h2) begin
      ext_cnt_r <= 2'h0;
      ext_clk_o <= ~ext_clk_o;
    end else begin
      ext_cnt_r <= ext_cnt_r + 2'h1;
    end
  end

  // The product only exists while the multiplier is powered; it toggles every core cycle.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mult_x32_o <= 1'b0;
    end else begin
      mult_x32_o <= mult_on_i ? ~mult_x32_o : 1'b0;
    end
  end

  // The timer overflows once every 64 cycles of running.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_run_o <= 1'b0;
      pwm_cnt_r <= 6'h00;
      pwm_ovf_o <= 1'b0;
    end else begin
      pwm_run_o <= run_req_i;
      pwm_cnt_r <= pwm_run_o ? pwm_cnt_r + 6'h01 : 6'h00;
      pwm_ovf_o <= pwm_run_o && (pwm_cnt_r == 6'h3f);
    end
  end
endmodule : ccp_far

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.svh"

module tb_top;
  import ccp_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, strap = 1'b0, halt = 1'b0, run_req = 1'b0;
  logic ext_clk, mult_x32, pwm_run, pwm_ovf, mult_on;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs, wr_resp;
  ccp_src_e clk_src;
  logic osc_run, ref_clk, mref_clk, ins_clk, fast_clk, pwm_clk;
  logic [5:0] sv, sp = 6'h00;
  int cnt [6] = '{default: 0};
  int base [6];
  int d [6];
  int n_errors = 0, checks = 0, cyc = 0;

  always #20 clk = ~clk;

  ccp_far ccp_far_inst (.clk_i(clk), .rst_n_i(nrst), .run_req_i(run_req), .mult_on_i(mult_on),
    .ext_clk_o(ext_clk), .mult_x32_o(mult_x32), .pwm_run_o(pwm_run), .pwm_ovf_o(pwm_ovf));

  ccp_top ccp_top_inst (.CORE_CLK_I(clk), .NRST_I(nrst), .CLK_SRC_STRAP_I(strap),
    .EXT_CLK_I(ext_clk), .HALT_I(halt), .PWM_RUN_I(pwm_run), .PWM_OVF_I(pwm_ovf),
    .MULT_X32_I(mult_x32), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .CLK_SRC_O(clk_src), .OSC_RUN_O(osc_run),
    .SELECTED_REF_CLK_O(ref_clk), .MULT_REF_CLK_O(mref_clk), .MULT_ON_O(mult_on),
    .INSTR_CLK_O(ins_clk), .FAST_CORE_CLK_O(fast_clk), .PWM_TIMER_CLK_O(pwm_clk));

  // Rising edges of each clock output are counted so that frequency ratios can be compared.
  assign sv = {pwm_clk, fast_clk, mref_clk, ins_clk, ref_clk, mult_x32};
  always @(negedge clk) begin
    sp <= sv;
    for (int i = 0; i < 6; i++) if (sv[i] === 1'b1 && sp[i] === 1'b0) cnt[i]++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task near(input int a, input int b, input int tol);
    check(32'((a - b <= tol) && (b - a <= tol)), 32'h1);
  endtask : near

  task do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task axi_wr(input logic [31:0] a, input logic [31:0] dv);
    int t;
    logic ad, wd, ha, hw;
    ad = 1'b0;
    wd = 1'b0;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd) && t < 100) begin
      @(negedge clk);
      ha = awready === 1'b1;
      hw = wready === 1'b1;
      @(posedge clk);
      t++;
      if (ha && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (hw && !wd) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    ha = 1'b0;
    while (!ha && t < 200) begin
      @(negedge clk);
      ha = bvalid === 1'b1;
      wr_resp = bresp;
      @(posedge clk);
      t++;
    end
    if (!ha) n_errors++;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [31:0] a);
    int t;
    logic hs;
    t = 0;
    hs = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hs && t < 100) begin
      @(negedge clk);
      hs = arready === 1'b1;
      @(posedge clk);
      t++;
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs && t < 200) begin
      @(negedge clk);
      hs = rvalid === 1'b1;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      t++;
    end
    if (!hs) n_errors++;
    rready <= 1'b0;
  endtask : axi_rd

  // Skips the mux settling time, then counts edges over a fixed window.
  task win();
    repeat (30) @(posedge clk);
    base = cnt;
    repeat (240) @(posedge clk);
    for (int i = 0; i < 6; i++) d[i] = cnt[i] - base[i];
  endtask : win

  task t_reset();
    check(32'(clk_src), 32'(CCP_SRC_OSC));
    axi_rd(`CCP_OFF_CTRL);
    check(rd, 32'h0);
    axi_rd(`CCP_OFF_STATUS);
    check(rd, 32'h20);
    axi_rd(32'h10);
    check({30'h0, rs}, {30'h0, `CCP_RESP_SLVERR});
    axi_wr(32'h10, 32'h1);
    check({30'h0, wr_resp}, {30'h0, `CCP_RESP_SLVERR});
  endtask : t_reset

  task t_div();
    win();
    near(d[1], 240 / (2 * (int'(`CCP_OSC_HALF) + 1)), 1);
    near(d[2] * 2, d[1], 2);
    near(d[3], d[1], 1);
    near(d[5], d[2], 1);
    axi_wr(`CCP_OFF_CFG, 32'h1);
    win();
    near(d[3] * 2, d[1], 2);
    axi_wr(`CCP_OFF_CFG, 32'h0);
  endtask : t_div

  task t_guard();
    axi_wr(`CCP_OFF_CTRL, 32'h12);
    axi_rd(`CCP_OFF_CTRL);
    check(rd, 32'h0);
    check({31'h0, mult_on}, 32'h0);
    axi_wr(`CCP_OFF_CTRL, 32'h1);
    check({31'h0, mult_on}, 32'h1);
    repeat (20) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      axi_wr(`CCP_OFF_CTRL, 32'h13 | (k << 2));
      axi_rd(`CCP_OFF_CTRL);
      check(rd, 32'h13 | (k << 2));
      win();
      near(d[4] * 8, d[0], 8);
      near(d[2], d[4], 1);
      near(d[5] << (3 - k), d[0], 8);
      axi_rd(`CCP_OFF_STATUS);
      check(rd, 32'h38 | (k << 1));
    end
  endtask : t_guard

  task t_run();
    run_req <= 1'b1;
    repeat (3) @(posedge clk);
    axi_wr(`CCP_OFF_CTRL, 32'h10);
    axi_rd(`CCP_OFF_CTRL);
    check(rd, 32'h13);
    axi_rd(`CCP_OFF_STATUS);
    check(rd, 32'h3e);
    repeat (70) @(posedge clk);
    axi_rd(`CCP_OFF_STATUS);
    check(rd, 32'h38);
    run_req <= 1'b0;
    repeat (3) @(posedge clk);
    axi_wr(`CCP_OFF_CTRL, 32'h1);
    axi_wr(`CCP_OFF_CTRL, 32'h0);
    check({31'h0, mult_on}, 32'h0);
    win();
    near(d[2] * 2, d[1], 2);
  endtask : t_run

  task t_ext();
    strap <= 1'b1;
    do_reset();
    check(32'(clk_src), 32'(CCP_SRC_EXT));
    repeat (3) @(posedge clk);
    check({31'h0, osc_run}, 32'h0);
    axi_rd(`CCP_OFF_STATUS);
    check(rd, 32'h01);
    win();
    near(d[1], 40, 1);
    strap <= 1'b0;
    do_reset();
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, osc_run}, 32'h0);
    halt <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, osc_run}, 32'h1);
  endtask : t_ext

  task test_done();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    do_reset();
    t_reset();
    t_div();
    t_guard();
    t_run();
    t_ext();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
